// [hw/fbio_consts.svh]
// Constants for the fieldbus process-image block.
`ifndef FBIO_CONSTS_SVH
`define FBIO_CONSTS_SVH
`define FBIO_CLK_MHZ        125
`define FBIO_COOL_US        1000
`define FBIO_COOL_CYC       (`FBIO_COOL_US * `FBIO_CLK_MHZ)
`define FBIO_BLINK_MS       50
`define FBIO_BLINK_CYC      (`FBIO_BLINK_MS * 1000 * `FBIO_CLK_MHZ)
`define FBIO_ACT_HOLD_MS    200
`define FBIO_ACT_HOLD_CYC   (`FBIO_ACT_HOLD_MS * 1000 * `FBIO_CLK_MHZ)
`define FBIO_TEMP_OFFSET    (-50)
`define FBIO_OUT_RESET      8'h00
`endif

// [hw/fbio_pkg.sv]
// Types shared by the fieldbus process-image block.
package fbio_pkg;
    typedef logic [7:0] fbio_byte_t;
    typedef enum logic [1:0] {FBIO_NORMAL, FBIO_TRIPPED, FBIO_COOLING} fbio_prot_e;
endpackage

// [hw/fbio_out_guard.sv]
// One output channel's overload protection state machine.
`timescale 1ns/100ps
`include "fbio_consts.svh"
module fbio_out_guard
    import fbio_pkg::*;
#(
    parameter int COOL_CYC = `FBIO_COOL_CYC
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic overload_in,
    output logic      enable_out
);
    fbio_prot_e state;
    logic [31:0] cool_cnt;
    wire        cool_done = (cool_cnt == 32'h0000_0000);
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state    <= FBIO_NORMAL;
            cool_cnt <= 32'h0000_0000;
        end else begin
            unique case (state)
                FBIO_NORMAL: begin
                    if (overload_in) begin
                        state <= FBIO_TRIPPED;
                    end
                end
                FBIO_TRIPPED: begin
                    state    <= FBIO_COOLING;
                    cool_cnt <= 32'(COOL_CYC - 1);
                end
                FBIO_COOLING: begin
                    if (cool_done) begin
                        state <= FBIO_NORMAL;
                    end else begin
                        cool_cnt <= cool_cnt - 32'h0000_0001;
                    end
                end
                default: state <= FBIO_NORMAL;
            endcase
        end
    end
    assign enable_out = (state == FBIO_NORMAL);
    trip_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state == FBIO_NORMAL && overload_in |=> !enable_out [*2])
        else $error("Output not disabled after overload.");
endmodule

// [hw/fbio_process_image.sv]
// Process-image logic mapping telegram bytes to digital I/O and indicators.
`timescale 1ns/100ps
`include "fbio_consts.svh"
module fbio_process_image
    import fbio_pkg::*;
#(
    parameter int COOL_CYC     = `FBIO_COOL_CYC,
    parameter int BLINK_CYC    = `FBIO_BLINK_CYC,
    parameter int ACT_HOLD_CYC = `FBIO_ACT_HOLD_CYC
) (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        rx_valid_in,
    input  wire fbio_byte_t  rx_out_byte_in,
    input  wire logic        wdog_expired_in,
    input  wire logic [15:0] din_in,
    input  wire fbio_byte_t  temp_code_in,
    input  wire logic        out_supply_ok_in,
    input  wire logic [7:0]  overload_in,
    output fbio_byte_t       tx_byte0_out,
    output fbio_byte_t       tx_byte1_out,
    output fbio_byte_t       tx_byte2_out,
    output logic             tx_valid_out,
    output logic [7:0]       dout_out,
    output logic [15:0]      din_led_out,
    output logic [7:0]       dout_led_out,
    output logic             act_led_out
);
    // Address assignment and acyclic transfers live in the link layer; this block
    // only sees cyclic process data through a fixed byte mapping.
    logic [15:0] din_meta;
    logic [15:0] din_sync;
    logic [7:0]  ovl_meta;
    logic [7:0]  ovl_sync;
    logic        sup_meta;
    logic        sup_sync;
    logic        wd_meta;
    logic        wd_sync;
    fbio_byte_t  temp_meta;
    fbio_byte_t  temp_sync;
    fbio_byte_t  cmd;
    logic [7:0]  guard_en;
    logic [31:0] blink_cnt;
    logic [31:0] act_cnt;
    logic        blink_ph;
    logic        seen_rx;

    // Pins pass two flip-flops; an open input arrives low and reads as zero.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            din_meta  <= 16'h0000;
            din_sync  <= 16'h0000;
            ovl_meta  <= 8'h00;
            ovl_sync  <= 8'h00;
            sup_meta  <= 1'b0;
            sup_sync  <= 1'b0;
            wd_meta   <= 1'b0;
            wd_sync   <= 1'b0;
            temp_meta <= 8'h00;
            temp_sync <= 8'h00;
        end else begin
            din_meta  <= din_in;
            din_sync  <= din_meta;
            ovl_meta  <= overload_in;
            ovl_sync  <= ovl_meta;
            sup_meta  <= out_supply_ok_in;
            sup_sync  <= sup_meta;
            wd_meta   <= wdog_expired_in;
            wd_sync   <= wd_meta;
            temp_meta <= temp_code_in;
            temp_sync <= temp_meta;
        end
    end

    // The temperature byte is already coded as degrees plus 50, one count per degree.
    wire fbio_byte_t next_byte0 = din_sync[7:0];
    wire fbio_byte_t next_byte1 = din_sync[15:8];
    wire fbio_byte_t next_byte2 = temp_sync;
    wire fbio_byte_t next_cmd   = wd_sync ? `FBIO_OUT_RESET :
                                  (rx_valid_in ? rx_out_byte_in : cmd);
    wire [7:0]       next_dout  = cmd & guard_en;

    // Inputs are latched at each received telegram and sent in the next transmit.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_byte0_out <= 8'h00;
            tx_byte1_out <= 8'h00;
            tx_byte2_out <= 8'h00;
            tx_valid_out <= 1'b0;
        end else begin
            tx_valid_out <= rx_valid_in;
            if (rx_valid_in) begin
                tx_byte0_out <= next_byte0;
                tx_byte1_out <= next_byte1;
                tx_byte2_out <= next_byte2;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmd      <= `FBIO_OUT_RESET;
            dout_out <= `FBIO_OUT_RESET;
        end else begin
            cmd      <= next_cmd;
            dout_out <= next_dout;
        end
    end

    genvar g;
    for (g = 0; g < 8; g++) begin : guards
        fbio_out_guard #(.COOL_CYC(COOL_CYC)) u_guard (
            .clk_in      (clk_in),
            .rst_n_in    (rst_n_in),
            .overload_in (ovl_sync[g]),
            .enable_out  (guard_en[g])
        );
    end

    wire blink_tick = (blink_cnt == 32'h0000_0000);
    wire act_live   = (act_cnt != 32'h0000_0000);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            blink_cnt   <= 32'h0000_0000;
            act_cnt     <= 32'h0000_0000;
            blink_ph    <= 1'b0;
            act_led_out <= 1'b0;
        end else begin
            blink_cnt <= blink_tick ? 32'(BLINK_CYC - 1) : blink_cnt - 32'h0000_0001;
            if (rx_valid_in) begin
                act_cnt <= 32'(ACT_HOLD_CYC);
            end else if (act_live) begin
                act_cnt <= act_cnt - 32'h0000_0001;
            end
            if (blink_tick) begin
                blink_ph <= ~blink_ph;
            end
            act_led_out <= act_live & blink_ph;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            din_led_out  <= 16'h0000;
            dout_led_out <= 8'h00;
        end else begin
            din_led_out  <= din_sync;
            dout_led_out <= cmd & {8{sup_sync}};
        end
    end

    out_update_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rx_valid_in && !wd_sync |=> cmd == $past(rx_out_byte_in))
        else $error("Command not taken from telegram.");
    wdog_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wd_sync |=> ##1 dout_out == 8'h00)
        else $error("Outputs not zero after watchdog.");
    tx_sample_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rx_valid_in |=> tx_valid_out && tx_byte0_out == $past(din_sync[7:0])
                        && tx_byte1_out == $past(din_sync[15:8]))
        else $error("Inputs not sampled into transmit.");
    temp_map_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rx_valid_in |=> tx_byte2_out == $past(temp_sync))
        else $error("Temperature byte wrong.");
    out_led_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !sup_sync |=> dout_led_out == 8'h00)
        else $error("Output indicator lit without supply.");
    in_led_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        1'b1 |=> din_led_out == $past(din_sync))
        else $error("Input indicator wrong.");
    out_guard_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        1'b1 |=> (dout_out & ~$past(guard_en)) == 8'h00)
        else $error("Disabled output driven.");
    wire [7:0] trip_now = ovl_sync & guard_en;
    overload_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (|trip_now) |=> ##1 (dout_out & $past(trip_now, 2)) == 8'h00)
        else $error("Overloaded output not disabled.");
    act_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !act_live |=> !act_led_out)
        else $error("Activity indicator lit while idle.");

    // Set by the first telegram after reset; until then the outputs must stay off.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seen_rx <= 1'b0;
        end else if (rx_valid_in) begin
            seen_rx <= 1'b1;
        end
    end

    sequence telegram_taken_s;
        rx_valid_in && !wd_sync;
    endsequence

    sequence outputs_applied_s;
        ##2 dout_out == ($past(rx_out_byte_in, 2) & $past(guard_en));
    endsequence

    out_apply_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        telegram_taken_s |-> outputs_applied_s)
        else $error("Outputs not applied from telegram.");

    boot_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !seen_rx |-> dout_out == 8'h00)
        else $error("Outputs driven before first telegram.");

    wdog_cmd_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wd_sync |=> cmd == 8'h00)
        else $error("Command not cleared by watchdog.");

    tx_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !rx_valid_in |=> !tx_valid_out)
        else $error("Transmit valid without telegram.");

    tx_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !rx_valid_in |=> $stable(tx_byte0_out) && $stable(tx_byte1_out)
                         && $stable(tx_byte2_out))
        else $error("Transmit bytes changed without telegram.");

    out_led_on_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        sup_sync |=> dout_led_out == $past(cmd))
        else $error("Output indicator does not follow command.");

    act_blink_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        act_live |=> act_led_out == $past(blink_ph))
        else $error("Activity indicator does not blink.");
endmodule

// [dv/fbio_master_model.sv]
// Behavioural fieldbus master that sends cyclic output telegrams.
`timescale 1ns/100ps
module fbio_master_model
    import fbio_pkg::*;
(
    output logic       rx_valid_out,
    output fbio_byte_t rx_byte_out,
    input  wire logic  clk_in
);
    initial begin
        rx_valid_out = 1'b0;
        rx_byte_out  = 8'h00;
    end
    // Only cyclic telegrams are sent; the byte is scrambled between telegrams.
    task automatic send(input fbio_byte_t b);
        @(posedge clk_in);
        rx_valid_out <= 1'b1;
        rx_byte_out  <= b;
        @(posedge clk_in);
        rx_valid_out <= 1'b0;
        rx_byte_out  <= ~b;
    endtask
endmodule

// [dv/test_fbio_process_image.sv]
// Self-checking testbench for the fieldbus process-image block.
`timescale 1ns/100ps
module test_fbio_process_image
    import fbio_pkg::*;
;
    localparam int COOL = 10;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        wdog = 1'b0;
    logic        supply = 1'b1;
    logic [15:0] din = 16'h0000;
    fbio_byte_t  temp = 8'h00;
    logic [7:0]  ovl = 8'h00;
    logic        rx_valid;
    fbio_byte_t  rx_byte;
    fbio_byte_t  tx0, tx1, tx2;
    logic        tx_valid, act;
    logic [7:0]  dout, dout_led;
    logic [15:0] din_led;
    int          err_total = 0;
    int          n_compared = 0;

    always #4 clk_in = ~clk_in;

    fbio_master_model u_fbio_master_model (.rx_valid_out(rx_valid), .rx_byte_out(rx_byte),
        .clk_in(clk_in));
    fbio_process_image #(.COOL_CYC(COOL), .BLINK_CYC(4), .ACT_HOLD_CYC(50)) u_fbio_process_image (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .rx_valid_in(rx_valid),
        .rx_out_byte_in(rx_byte), .wdog_expired_in(wdog), .din_in(din),
        .temp_code_in(temp), .out_supply_ok_in(supply), .overload_in(ovl),
        .tx_byte0_out(tx0), .tx_byte1_out(tx1), .tx_byte2_out(tx2),
        .tx_valid_out(tx_valid), .dout_out(dout), .din_led_out(din_led),
        .dout_led_out(dout_led), .act_led_out(act));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Sends one telegram and returns at the negedge where the answer pulse stands.
    task automatic xfer(input fbio_byte_t b);
        logic got;
        got = 1'b0;
        u_fbio_master_model.send(b);
        for (int i = 0; i < 8 && !got; i++) begin
            @(negedge clk_in);
            got = (tx_valid === 1'b1);
        end
        chk(16'(got), 16'h0001);
    endtask

    task automatic t_map;
        @(posedge clk_in);
        din  <= 16'hA53C;
        temp <= 8'h4B;
        repeat (4) @(posedge clk_in);
        xfer(8'h81);
        chk(16'(tx0), 16'h003C);
        chk(16'(tx1), 16'h00A5);
        chk(16'(tx2), 16'h004B);
        @(negedge clk_in);
        chk(16'(dout), 16'h0081);
        chk(16'(dout_led), 16'h0081);
        chk(din_led, 16'hA53C);
        @(posedge clk_in);
        din <= 16'h0000;
        repeat (4) @(posedge clk_in);
        xfer(8'h7E);
        chk({tx1, tx0}, 16'h0000);
        @(negedge clk_in);
        chk(16'(dout), 16'h007E);
        $display("done mapping");
    endtask

    task automatic t_supply;
        @(posedge clk_in);
        supply <= 1'b0;
        repeat (4) @(posedge clk_in);
        xfer(8'hFF);
        @(negedge clk_in);
        chk(16'(dout), 16'h00FF);
        chk(16'(dout_led), 16'h0000);
        @(posedge clk_in);
        supply <= 1'b1;
        $display("done supply");
    endtask

    task automatic t_wdog;
        @(posedge clk_in);
        wdog <= 1'b1;
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        chk(16'(dout), 16'h0000);
        xfer(8'hFF);
        @(negedge clk_in);
        chk(16'(dout), 16'h0000);
        @(posedge clk_in);
        wdog <= 1'b0;
        repeat (4) @(posedge clk_in);
        xfer(8'hFF);
        @(negedge clk_in);
        chk(16'(dout), 16'h00FF);
        $display("done watchdog");
    endtask

    task automatic t_ovl;
        logic back_on;
        back_on = 1'b0;
        @(posedge clk_in);
        ovl <= 8'h01;
        repeat (5) @(posedge clk_in);
        @(negedge clk_in);
        chk(16'(dout), 16'h00FE);
        repeat (COOL + 8) begin
            @(negedge clk_in);
            back_on |= (dout[0] === 1'b1);
        end
        chk(16'(back_on), 16'h0001);
        chk(16'(dout), 16'h00FE);
        @(posedge clk_in);
        ovl <= 8'h00;
        repeat (COOL + 8) @(negedge clk_in);
        chk(16'(dout), 16'h00FF);
        $display("done overload");
    endtask

    task automatic t_act;
        logic s1, s0;
        s1 = 1'b0;
        s0 = 1'b0;
        xfer(8'hFF);
        repeat (30) begin
            @(negedge clk_in);
            s1 |= (act === 1'b1);
            s0 |= (act === 1'b0);
        end
        chk(16'({s1, s0}), 16'h0003);
        repeat (30) @(negedge clk_in);
        s1 = 1'b0;
        repeat (20) begin
            @(negedge clk_in);
            s1 |= (act !== 1'b0);
        end
        chk(16'(s1), 16'h0000);
        $display("done activity");
    endtask

    task automatic t_reset;
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(negedge clk_in);
        chk(16'(dout), 16'h0000);
        chk(16'(dout_led), 16'h0000);
        repeat (4) @(negedge clk_in);
        chk(16'(dout), 16'h0000);
        xfer(8'h5A);
        @(negedge clk_in);
        chk(16'(dout), 16'h005A);
        $display("done reset");
    endtask

    initial begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(negedge clk_in);
        chk(16'(dout), 16'h0000);
        t_map();
        t_supply();
        t_wdog();
        t_ovl();
        t_act();
        t_reset();
        wrap_up();
    end

    initial begin
        #40000;
        err_total++;
        wrap_up();
    end
endmodule
